// ---- bench/dbwp_cpu_model.sv ----
// Model of the CPU load/store path that the breakpoint unit snoops
`timescale 1ns/100ps
`default_nettype none
module dbwp_cpu_model (
  input wire logic clk,
  output logic acc_valid,
  output logic acc_genuine,
  output logic acc_cached,
  output logic acc_write,
  output dbwp_pkg::dbwp_size_t acc_size,
  output logic [31:0] acc_addr,
  output logic [63:0] acc_data,
  output logic acc_mem_commit,
  output logic ldst_done
);
  import dbwp_pkg::*;
  // Bus idle at start
  initial begin
    {acc_valid, acc_genuine, acc_cached, acc_write, acc_mem_commit, ldst_done} = 6'h00;
    acc_size = DBWP_SZ_WORD;
    acc_addr = 32'h0;
    acc_data = 64'h0;
  end
  // One aligned transfer, the memory write of an uncached store, then completion
  task automatic xfer(input logic wr, input dbwp_size_t sz, input logic [31:0] ad,
    input logic [63:0] dt, input logic gn, input logic ch);
    logic unc;
    unc = wr & ~ch;
    @(posedge clk);
    {acc_valid, acc_write, acc_genuine, acc_cached} <= {1'b1, wr, gn, ch};
    acc_size <= sz;
    acc_addr <= ad;
    acc_data <= dt;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_mem_commit <= unc;
    ldst_done <= ~unc;
    if (unc) begin
      @(posedge clk);
      acc_mem_commit <= 1'b0;
      ldst_done <= 1'b1;
    end
    @(posedge clk);
    ldst_done <= 1'b0;
    // Released lines invert so a stale value can never match by accident
    acc_addr <= ~acc_addr;
    acc_data <= ~acc_data;
  endtask
endmodule
`default_nettype wire

// ---- bench/dbwp_top_tb_top.sv ----
// Self-checking bench for the data breakpoint and watchpoint unit
`timescale 1ns/100ps
`default_nettype none
module dbwp_top_tb_top;
  import dbwp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, monitor_mode = 1'b0, trig_data_trace = 1'b0;
  logic [7:0] mmu_asid = 8'h5a, sm = 8'h00, sp = 8'h00, wh;
  logic [31:0] ca = 32'h0, cb = 32'h0, aa = 32'h0, ab = 32'h0, da = 32'h0, db = 32'h0;
  logic [2:0] pair = 3'h0;
  logic [5:0] pw = 6'h00, wt, tt;
  logic [1:0] tw = 2'h0, th, tm;
  logic hr, wv, tv, de;
  wire logic acc_valid, acc_genuine, acc_cached, acc_write, acc_mem_commit, ldst_done;
  wire dbwp_size_t acc_size;
  wire logic [31:0] acc_addr;
  wire logic [63:0] acc_data;
  int miscompares = 0, tests_run = 0, nde;
  always #10 clk = ~clk;
  dbwp_cpu_model u_dbwp_cpu_model (.clk, .acc_valid, .acc_genuine, .acc_cached,
    .acc_write, .acc_size, .acc_addr, .acc_data, .acc_mem_commit, .ldst_done);
  dbwp_top u_dbwp_top (.clk, .rst_n, .acc_valid, .acc_genuine, .acc_cached, .acc_write,
    .acc_size, .acc_addr, .acc_data, .acc_mem_commit, .ldst_done, .monitor_mode, .mmu_asid,
    .compare_address_reg_a(aa), .compare_address_reg_b(ab), .compare_data_reg_a(da),
    .compare_data_reg_b(db), .compare_control_reg_a(ca), .compare_control_reg_b(cb),
    .data_pair_control(pair), .pc_watch_hit(pw), .trace_watch_hit(tw), .trig_start_mask(sm),
    .trig_stop_mask(sp), .trig_data_trace, .halt_req(hr), .watch_hit_message_valid(wv),
    .watch_hit_message_hits(wh), .watch_hit_message_tcode(wt),
    .trace_watch_hit_message_valid(tv), .trace_watch_hit_message_hits(th),
    .trace_watch_hit_message_tcode(tt), .trace_mode_field(tm), .data_trace_event(de));
  // Count a comparison and report a mismatch at once
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (!ok) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Control word: action, access type, lane mask, size select; space id fields left zero
  function automatic logic [31:0] ctl(input logic [1:0] act, input logic [1:0] typ,
    input logic [3:0] msk, input logic [2:0] sz);
    return {act, typ, 4'h0, msk, 2'h0, sz, 15'h0000};
  endfunction
  task automatic setup(input logic [31:0] c0, c1, a0, a1, d0, d1, input logic [2:0] p);
    @(posedge clk);
    {ca, cb, aa, ab, da, db, pair} <= {c0, c1, a0, a1, d0, d1, p};
  endtask
  // One transfer with a seven-cycle window long enough for the uncached halt
  task automatic run(input logic wr, input dbwp_size_t sz, input logic [31:0] ad,
    input logic [63:0] dt, input logic [1:0] gc, input logic [7:0] ew, input int eh);
    logic [7:0] w;
    int h;
    {w, h, nde} = '0;
    fork
      u_dbwp_cpu_model.xfer(wr, sz, ad, dt, gc[1], gc[0]);
      repeat (7) begin
        @(posedge clk);
        #1;
        if (wv === 1'b1) check(wt === WH_TCODE, "watch code");
        w = (wv === 1'b1) ? (w | wh) : w;
        h = h + int'(hr === 1'b1);
        nde = nde + int'(de === 1'b1);
      end
    join
    check(w === ew, "watch hit field");
    check(h == eh, "halt count");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] wc;
    wc = ctl(2'b11, 2'b10, 4'h0, 3'h0);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    setup(wc, 32'h0, 32'h8000, 32'h0, 32'h1234_5678, 32'h0, 3'h0);
    run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11, 8'h40, 0);
    run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b01, 8'h00, 0);
    run(1, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b10, 8'h40, 0);
    @(posedge clk);
    monitor_mode <= 1'b1;
    run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11, 8'h00, 0);
    @(posedge clk);
    monitor_mode <= 1'b0;
    // Every action code, then again behind a space id mismatch; every access type
    for (int a = 0; a < 8; a++) begin
      setup(ctl(a[1:0], 2'b10, 4'h0, 3'h0) | {31'h0, a[2]}, 32'h0, 32'h8000, 32'h0,
        32'h1234_5678, 32'h0, 3'h0);
      run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11, (a == 3) ? 8'h40 : 8'h00,
        int'(a == 1));
    end
    for (int t = 0; t < 8; t++) begin
      setup(ctl(2'b11, t[2:1], 4'h0, 3'h0), 32'h0, 32'h8000, 32'h0, 32'h1234_5678, 32'h0, 3'h0);
      run(t[0], DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11,
        (t[2:1] == 2 || t[2:1] == t[0]) ? 8'h40 : 8'h00, 0);
    end
    // Byte 1 inside a word, space id matching: lane mask, then size select demanding a byte
    setup(ctl(2'b11, 2'b10, 4'he, 3'h0) | 32'hb5, 32'h0, 32'h8001, 32'h0,
      32'h55, 32'h0, 3'h0);
    run(0, DBWP_SZ_WORD, 32'h8000, 64'haa55_ccdd, 2'b11, 8'h40, 0);
    run(0, DBWP_SZ_WORD, 32'h8000, 64'haa56_ccdd, 2'b11, 8'h00, 0);
    setup(ctl(2'b11, 2'b10, 4'he, 3'h4), 32'h0, 32'h8001, 32'h0, 32'h55, 32'h0, 3'h0);
    run(0, DBWP_SZ_WORD, 32'h8000, 64'haa55_ccdd, 2'b11, 8'h00, 0);
    run(0, DBWP_SZ_BYTE, 32'h8001, 64'h55, 2'b11, 8'h40, 0);
    // Combined double word; the B action asks for a watch that must not show
    setup(wc, 32'he000_0000, 32'h800c, 32'h8008, 32'h89ab_cdef, 32'h0123_4567, 3'h4);
    run(1, DBWP_SZ_DWORD, 32'h8008, 64'h0123_4567_89ab_cdef, 2'b11, 8'h40, 0);
    run(1, DBWP_SZ_DWORD, 32'h8008, 64'h0123_4566_89ab_cdef, 2'b11, 8'h00, 0);
    // Ranges with value compare masked off and B silent
    for (int r = 0; r < 4; r++) begin
      setup(ctl(2'b11, 2'b10, 4'hf, 3'h0), ctl(2'b11, 2'b10, 4'hf, 3'h0), 32'h100, 32'h200,
        32'h0, 32'h0, (r < 2) ? 3'h2 : 3'h1);
      run(0, DBWP_SZ_BYTE, r[0] ? 32'h100 : 32'h200, 64'h0, 2'b11,
        (r == 0 || r == 3) ? 8'h40 : 8'h00, 0);
    end
    // Trace hit alone is reported, beside a program hit it is dropped
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {tw, pw} <= {2'b10, 5'h00, k[0]};
      @(posedge clk);
      {tw, pw} <= 8'h00;
      #1;
      check(tv === ~k[0] && wv === k[0], "trace hit drop");
      check(k[0] || (th === 2'b10 && tt === TWH_TCODE), "trace hit field");
    end
    // Program hit of a load precedes its data hit
    setup(wc, 32'h0, 32'h8000, 32'h0, 32'h1234_5678, 32'h0, 3'h0);
    fork
      u_dbwp_cpu_model.xfer(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 1'b1, 1'b1);
      begin
        @(posedge clk);
        pw <= 6'h01;
        @(posedge clk);
        pw <= 6'h00;
        #1;
        check(wv === 1'b1 && wh === 8'h01, "program hit first");
        @(posedge clk);
        #1;
        check(wv === 1'b1 && wh === 8'h40, "data hit second");
      end
    join
    // Watch starts data trace without its own event, then stops it with it
    @(posedge clk);
    {sm, trig_data_trace} <= {8'h40, 1'b1};
    run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11, 8'h40, 0);
    check(tm === 2'b10 && nde == 0, "trace start");
    run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11, 8'h40, 0);
    check(nde == 1, "traced event");
    @(posedge clk);
    {sm, sp} <= {8'h00, 8'h40};
    run(0, DBWP_SZ_WORD, 32'h8000, 64'h1234_5678, 2'b11, 8'h40, 0);
    check(tm === 2'b00 && nde == 1, "trace stop");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- verilog/dbwp_cmp.sv ----
// One data compare module: address, value, type, size and space qualifiers
`timescale 1ns/100ps
`default_nettype none
module dbwp_cmp (
  input wire logic [31:0] acc_addr,
  input wire dbwp_pkg::dbwp_size_t acc_size,
  input wire logic acc_write,
  input wire logic [63:0] acc_data,
  input wire logic [7:0] mmu_asid,
  input wire logic [31:0] compare_address_reg,
  input wire logic [31:0] compare_data_reg,
  input wire logic [31:0] compare_control_reg,
  output logic addr_hit,
  output logic qual_ok,
  output logic data_ok
);
  import dbwp_pkg::*;

  logic [2:0] align_keep;
  logic [31:0] lane;
  logic [31:0] val;
  logic [3:0] byte_lane_mask;
  logic [1:0] watch_bytes_m1;
  logic [1:0] lsb_pos;
  logic [1:0] acc_shift;
  dbwp_acc_t access_type_select;

  assign byte_lane_mask = compare_control_reg[MASK_HI:MASK_LO];
  assign access_type_select = dbwp_acc_t'(compare_control_reg[ATYP_HI:ATYP_LO]);

  // ---------------------------------------------------------------
  // Address: aligned transfer covers the watched byte
  // ---------------------------------------------------------------
  always_comb begin
    case (acc_size)
      DBWP_SZ_BYTE: align_keep = 3'h7;
      DBWP_SZ_HALF: align_keep = 3'h6;
      DBWP_SZ_WORD: align_keep = 3'h4;
      default: align_keep = 3'h0;
    endcase
  end
  assign addr_hit = (compare_address_reg[31:3] == acc_addr[31:3]) &&
                    ((compare_address_reg[2:0] & align_keep) == acc_addr[2:0]);

  // Bring the transfer into big-endian word lane order
  always_comb begin
    acc_shift = 2'h0;
    lane = acc_data[31:0];
    case (acc_size)
      DBWP_SZ_BYTE: acc_shift = 2'h3 - acc_addr[1:0];
      DBWP_SZ_HALF: acc_shift = 2'h2 - acc_addr[1:0];
      DBWP_SZ_WORD: acc_shift = 2'h0;
      default: acc_shift = 2'h0;
    endcase
    if (acc_size == DBWP_SZ_DWORD) begin
      lane = compare_address_reg[2] ? acc_data[31:0] : acc_data[63:32];
    end else begin
      lane = acc_data[31:0] << {acc_shift, 3'h0};
    end
  end

  // ---------------------------------------------------------------
  // Value: watched unit is moved to the LSB, then masked per lane
  // ---------------------------------------------------------------
  always_comb begin
    if (byte_lane_mask[3:1] == 3'h7) begin
      watch_bytes_m1 = 2'h0;
    end else if (byte_lane_mask[3:2] == 2'h3) begin
      watch_bytes_m1 = 2'h1;
    end else begin
      watch_bytes_m1 = 2'h3;
    end
    lsb_pos = 2'h3 - compare_address_reg[1:0];
    // A unit that straddles a word cannot be watched; clamp instead of wrapping
    val = (lsb_pos >= watch_bytes_m1) ? (lane >> {lsb_pos - watch_bytes_m1, 3'h0}) : lane;
  end
  assign data_ok = ((val ^ compare_data_reg) &
                    ~{{8{byte_lane_mask[3]}}, {8{byte_lane_mask[2]}},
                      {8{byte_lane_mask[1]}}, {8{byte_lane_mask[0]}}}) == 32'h0;

  // ---------------------------------------------------------------
  // Qualifiers: access type, optional exact size, address space
  // ---------------------------------------------------------------
  always_comb begin
    qual_ok = 1'b1;
    case (access_type_select)
      DBWP_ACC_READ: qual_ok = ~acc_write;
      DBWP_ACC_WRITE: qual_ok = acc_write;
      DBWP_ACC_ANY: qual_ok = 1'b1;
      default: qual_ok = 1'b0;
    endcase
    if (compare_control_reg[SIZE_EN_BIT] &&
        (compare_control_reg[SIZE_HI:SIZE_LO] != acc_size)) begin
      qual_ok = 1'b0;
    end
    if (compare_control_reg[ASIDEN_BIT] &&
        (compare_control_reg[ASID_HI:ASID_LO] != mmu_asid)) begin
      qual_ok = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/dbwp_pkg.sv ----
// Shared constants for the data breakpoint and watchpoint unit
package dbwp_pkg;
  // ---------------------------------------------------------------
  // Compare control register field positions
  // ---------------------------------------------------------------
  localparam int ACT_HI = 31;
  localparam int ACT_LO = 30;
  localparam int ATYP_HI = 29;
  localparam int ATYP_LO = 28;
  localparam int MASK_HI = 23;
  localparam int MASK_LO = 20;
  localparam int SIZE_EN_BIT = 17;
  localparam int SIZE_HI = 16;
  localparam int SIZE_LO = 15;
  localparam int ASID_HI = 8;
  localparam int ASID_LO = 1;
  localparam int ASIDEN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Pair control field positions and codes
  // ---------------------------------------------------------------
  localparam int DWC_BIT = 2;
  localparam int RNG_HI = 1;
  localparam int RNG_LO = 0;
  localparam logic [2:0] PAIR_RESET = 3'h0;

  typedef enum logic [1:0] {
    DBWP_ACT_OFF = 2'b00,
    DBWP_ACT_BRK = 2'b01,
    DBWP_ACT_RSV = 2'b10,
    DBWP_ACT_WATCH = 2'b11
  } dbwp_act_t;

  typedef enum logic [1:0] {
    DBWP_ACC_READ = 2'b00,
    DBWP_ACC_WRITE = 2'b01,
    DBWP_ACC_ANY = 2'b10,
    DBWP_ACC_RSV = 2'b11
  } dbwp_acc_t;

  typedef enum logic [1:0] {
    DBWP_RNG_OFF = 2'b00,
    DBWP_RNG_EXCL = 2'b01,
    DBWP_RNG_INCL = 2'b10,
    DBWP_RNG_RSV = 2'b11
  } dbwp_rng_t;

  // Transfer size codes: byte, halfword, word, double word
  typedef enum logic [1:0] {
    DBWP_SZ_BYTE = 2'b00,
    DBWP_SZ_HALF = 2'b01,
    DBWP_SZ_WORD = 2'b10,
    DBWP_SZ_DWORD = 2'b11
  } dbwp_size_t;

  // ---------------------------------------------------------------
  // Message codes and widths
  // ---------------------------------------------------------------
  localparam int WH_HIT_W = 8;
  localparam int TWH_HIT_W = 2;
  localparam int TCODE_W = 6;
  localparam logic [5:0] WH_TCODE = 6'h0f;
  localparam logic [5:0] TWH_TCODE = 6'h38;
  localparam int PC_WP_N = 6;
  localparam int DATA_WP_A = 6;
  localparam int DATA_WP_B = 7;
  localparam int TM_PROG_BIT = 0;
  localparam int TM_DATA_BIT = 1;
endpackage

// ---- verilog/dbwp_top.sv ----
// Data breakpoint and watchpoint unit with trace trigger and hit messages
// Contract
// - Watchpoint action sends a hit message instead of halting the processor.
// - Simultaneous trace and ordinary watchpoints: trace one dropped, ordinary sent; a same-cycle data hit does not drop it, one a cycle earlier does.
// - For one load/store, program watchpoint reported before data watchpoint.
// - Data breakpoint halts after the load/store completes, on the next instruction.
// - Virtual address compare; optional space identifier match against MMU value.
// - Only genuine CPU load/store transfers are observed; prefetch and maintenance ignored.
// - Cached store triggers at issue; uncached store triggers when written to memory.
// - No data breakpoint or watchpoint fires in monitor debug mode.
// - Transfers are aligned; double word compares the lane of the programmed address.
// - Masked byte lanes drop out of value compare; 0xE keeps only LSB.
// - Value match ignores size unless size select demands an exact size.
// - Double-word combine: module A triggers only when both modules match.
// - In combined mode module A action governs; module B action ignored.
// - Split unaligned accesses are seen and compared as individual aligned transfers.
// - Range code 10 is A < addr <= B; code 01 is addr <= A or addr > B.
// - With range enabled module A action governs; module B never matches alone.
// - Watchpoints start or stop program or data trace, updating trace mode field.
// - Data event that starts data trace is omitted; one that stops it is kept.
// - Watch hit message: 8-bit per-watchpoint hit field and code 15.
// - Trace watch hit message: 2-bit hit field and code 56.
// - Action field: 00 off, 01 breakpoint, 11 watchpoint, 10 reserved.
// - Access type: 00 read, 01 write, 10 any, 11 reserved.
// - Mask bit 3 covers data 31:24, bit 0 covers data 7:0.
`timescale 1ns/100ps
`default_nettype none
module dbwp_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic acc_genuine,
  input wire logic acc_cached,
  input wire logic acc_write,
  input wire dbwp_pkg::dbwp_size_t acc_size,
  input wire logic [31:0] acc_addr,
  input wire logic [63:0] acc_data,
  input wire logic acc_mem_commit,
  input wire logic ldst_done,
  input wire logic monitor_mode,
  input wire logic [7:0] mmu_asid,
  input wire logic [31:0] compare_address_reg_a,
  input wire logic [31:0] compare_address_reg_b,
  input wire logic [31:0] compare_data_reg_a,
  input wire logic [31:0] compare_data_reg_b,
  input wire logic [31:0] compare_control_reg_a,
  input wire logic [31:0] compare_control_reg_b,
  input wire logic [2:0] data_pair_control,
  input wire logic [dbwp_pkg::PC_WP_N-1:0] pc_watch_hit,
  input wire logic [dbwp_pkg::TWH_HIT_W-1:0] trace_watch_hit,
  input wire logic [dbwp_pkg::WH_HIT_W-1:0] trig_start_mask,
  input wire logic [dbwp_pkg::WH_HIT_W-1:0] trig_stop_mask,
  input wire logic trig_data_trace,
  output logic halt_req,
  output logic watch_hit_message_valid,
  output logic [dbwp_pkg::WH_HIT_W-1:0] watch_hit_message_hits,
  output logic [dbwp_pkg::TCODE_W-1:0] watch_hit_message_tcode,
  output logic trace_watch_hit_message_valid,
  output logic [dbwp_pkg::TWH_HIT_W-1:0] trace_watch_hit_message_hits,
  output logic [dbwp_pkg::TCODE_W-1:0] trace_watch_hit_message_tcode,
  output logic [1:0] trace_mode_field,
  output logic data_trace_event
);
  import dbwp_pkg::*;

  // ---------------------------------------------------------------
  // Transfer qualification
  // ---------------------------------------------------------------
  logic look;
  logic a_addr_hit, a_qual, a_data;
  logic b_addr_hit, b_qual, b_data;
  logic a_match, b_match;
  logic range_hit, a_fire, b_fire;
  dbwp_act_t act_a, act_b;
  dbwp_rng_t range_select;
  logic double_word_combine;
  logic [1:0] dwp_now;
  logic [1:0] dbp_now;
  logic [WH_HIT_W-1:0] hits_now;
  logic [WH_HIT_W-1:0] hits_msg;
  logic [1:0] dwp_d1_r;
  logic brk_pend_r;
  logic halt_r;
  logic wh_valid_r;
  logic [WH_HIT_W-1:0] wh_hits_r;
  logic twh_valid_r;
  logic [TWH_HIT_W-1:0] twh_hits_r;
  logic [1:0] tm_r;
  logic [1:0] tm_nxt;
  logic dte_r;

  // Cached stores and loads count at issue; uncached stores only at the memory write.
  // Monitor mode shuts the whole data compare off.
  assign look = ~monitor_mode &
                ((acc_valid & acc_genuine & (acc_cached | ~acc_write)) |
                 (acc_mem_commit & acc_genuine & ~acc_cached & acc_write));

  assign act_a = dbwp_act_t'(compare_control_reg_a[ACT_HI:ACT_LO]);
  assign act_b = dbwp_act_t'(compare_control_reg_b[ACT_HI:ACT_LO]);
  assign range_select = dbwp_rng_t'(data_pair_control[RNG_HI:RNG_LO]);
  assign double_word_combine = data_pair_control[DWC_BIT];

  // ---------------------------------------------------------------
  // Two compare modules share the snooped transfer
  // ---------------------------------------------------------------
  // Each split piece of an unaligned access arrives as its own transfer
  dbwp_cmp u_cmp_a (
    .acc_addr(acc_addr),
    .acc_size(acc_size),
    .acc_write(acc_write),
    .acc_data(acc_data),
    .mmu_asid(mmu_asid),
    .compare_address_reg(compare_address_reg_a),
    .compare_data_reg(compare_data_reg_a),
    .compare_control_reg(compare_control_reg_a),
    .addr_hit(a_addr_hit),
    .qual_ok(a_qual),
    .data_ok(a_data)
  );

  dbwp_cmp u_cmp_b (
    .acc_addr(acc_addr),
    .acc_size(acc_size),
    .acc_write(acc_write),
    .acc_data(acc_data),
    .mmu_asid(mmu_asid),
    .compare_address_reg(compare_address_reg_b),
    .compare_data_reg(compare_data_reg_b),
    .compare_control_reg(compare_control_reg_b),
    .addr_hit(b_addr_hit),
    .qual_ok(b_qual),
    .data_ok(b_data)
  );

  assign a_match = a_addr_hit & a_qual & a_data;
  assign b_match = b_addr_hit & b_qual & b_data;

  // Range bounds use the raw virtual address; value compare is left to the mask,
  // since clearing it is the debugger's duty and no interlock is built.
  always_comb begin
    case (range_select)
      DBWP_RNG_INCL: range_hit = (compare_address_reg_a < acc_addr) &&
                                 (acc_addr <= compare_address_reg_b);
      DBWP_RNG_EXCL: range_hit = (acc_addr <= compare_address_reg_a) ||
                                 (acc_addr > compare_address_reg_b);
      default: range_hit = 1'b0;
    endcase
  end

  // Module A fire condition in single, combined and ranged operation
  always_comb begin
    if (range_select == DBWP_RNG_INCL || range_select == DBWP_RNG_EXCL) begin
      a_fire = look & range_hit & a_qual & a_data;
      b_fire = 1'b0;
    end else if (double_word_combine) begin
      a_fire = look & a_match & b_match;
      b_fire = 1'b0;
    end else begin
      a_fire = look & a_match;
      b_fire = look & b_match;
    end
  end

  // Action decode; reserved code behaves as disabled
  assign dwp_now = {b_fire & (act_b == DBWP_ACT_WATCH),
                    a_fire & (act_a == DBWP_ACT_WATCH)};
  assign dbp_now = {b_fire & (act_b == DBWP_ACT_BRK),
                    a_fire & (act_a == DBWP_ACT_BRK)};

  // ---------------------------------------------------------------
  // Breakpoint halt after the load/store completes
  // ---------------------------------------------------------------
  // A hit on the last piece may coincide with completion; then nothing is left pending and the halt comes from dbp_now directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_pend_r <= 1'b0;
    end else if (|dbp_now) begin
      brk_pend_r <= ~ldst_done;
    end else if (ldst_done || monitor_mode) begin
      brk_pend_r <= 1'b0;
    end
  end

  // Halt pulse lands the cycle after completion, i.e. on the following instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
    end else begin
      halt_r <= ldst_done & (brk_pend_r | (|dbp_now)) & ~monitor_mode;
    end
  end
  assign halt_req = halt_r;

  // ---------------------------------------------------------------
  // Watch hit messages
  // ---------------------------------------------------------------
  // Data watch hits lag one stage so a program hit of the same instruction goes first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwp_d1_r <= 2'h0;
    end else begin
      dwp_d1_r <= dwp_now;
    end
  end

  assign hits_msg = {dwp_d1_r, pc_watch_hit};
  assign hits_now = {dwp_now, pc_watch_hit};

  // One bit per watchpoint; data modules sit at bits six and seven
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wh_valid_r <= 1'b0;
      wh_hits_r <= '0;
    end else begin
      wh_valid_r <= |hits_msg;
      wh_hits_r <= hits_msg;
    end
  end

  // Trace watchpoint is lost whenever an ordinary hit goes out in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      twh_valid_r <= 1'b0;
      twh_hits_r <= '0;
    end else begin
      twh_valid_r <= (|trace_watch_hit) & ~(|hits_msg);
      twh_hits_r <= (|hits_msg) ? '0 : trace_watch_hit;
    end
  end

  assign watch_hit_message_valid = wh_valid_r;
  assign watch_hit_message_hits = wh_hits_r;
  assign watch_hit_message_tcode = WH_TCODE;
  assign trace_watch_hit_message_valid = twh_valid_r;
  assign trace_watch_hit_message_hits = twh_hits_r;
  assign trace_watch_hit_message_tcode = TWH_TCODE;

  // ---------------------------------------------------------------
  // Trace trigger unit
  // ---------------------------------------------------------------
  // Start beats stop when one watchpoint pattern asks for both
  always_comb begin
    tm_nxt = tm_r;
    if (|(hits_now & trig_stop_mask)) begin
      tm_nxt[trig_data_trace] = 1'b0;
    end
    if (|(hits_now & trig_start_mask)) begin
      tm_nxt[trig_data_trace] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tm_r <= 2'h0;
    end else begin
      tm_r <= tm_nxt;
    end
  end
  assign trace_mode_field = tm_r;

  // Uses the mode before this access's own trigger takes effect, which drops
  // the event that switches trace on and keeps the one that switches it off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dte_r <= 1'b0;
    end else begin
      dte_r <= look & tm_r[TM_DATA_BIT];
    end
  end
  assign data_trace_event = dte_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_single_watch_a;
    look && a_match && (act_a == DBWP_ACT_WATCH) && (range_select == DBWP_RNG_OFF) &&
      !double_word_combine && (pc_watch_hit == '0);
  endsequence

  sequence s_msg_out_a;
    ##2 (watch_hit_message_valid && watch_hit_message_hits[DATA_WP_A]);
  endsequence

  a_watch_msg_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_single_watch_a |-> s_msg_out_a)
    else $error("data watch hit did not yield a message two cycles later");

  a_watch_no_halt: assert property (@(posedge clk) disable iff (!rst_n)
    (dbp_now == 2'h0 && !brk_pend_r) |=> !halt_req)
    else $error("halt without any data breakpoint");

  a_twh_dropped: assert property (@(posedge clk) disable iff (!rst_n)
    ((|trace_watch_hit) && (|hits_msg)) |=> !trace_watch_hit_message_valid)
    else $error("trace watch message not dropped under ordinary hit");

  a_prog_first: assert property (@(posedge clk) disable iff (!rst_n)
    ((dwp_now != 2'h0) && (dwp_d1_r == 2'h0))
      |=> (watch_hit_message_hits[DATA_WP_B:DATA_WP_A] == 2'h0))
    else $error("data watch hit reported too early");

  sequence s_brk_then_done;
    (look && a_fire && act_a == DBWP_ACT_BRK && !ldst_done && !monitor_mode)
      ##1 (ldst_done && !monitor_mode);
  endsequence

  a_halt_after_done: assert property (@(posedge clk) disable iff (!rst_n)
    s_brk_then_done |=> halt_req)
    else $error("halt missing after load/store completion");

  a_halt_not_early: assert property (@(posedge clk) disable iff (!rst_n)
    halt_req |-> $past(ldst_done))
    else $error("halt issued before completion");

  a_monitor_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    monitor_mode |-> (dwp_now == 2'h0) && (dbp_now == 2'h0))
    else $error("data compare active in monitor mode");

  a_prefetch_blind: assert property (@(posedge clk) disable iff (!rst_n)
    (!acc_genuine) |-> !a_fire && !b_fire)
    else $error("non-genuine transfer produced a match");

  a_pair_b_mute: assert property (@(posedge clk) disable iff (!rst_n)
    (double_word_combine || range_select == DBWP_RNG_INCL || range_select == DBWP_RNG_EXCL)
      |-> !b_fire)
    else $error("module B matched alone in paired mode");

  a_dword_both: assert property (@(posedge clk) disable iff (!rst_n)
    (double_word_combine && range_select == DBWP_RNG_OFF && a_fire) |-> (a_match && b_match))
    else $error("combined compare fired without both halves");

  a_trace_start: assert property (@(posedge clk) disable iff (!rst_n)
    ((|(hits_now & trig_start_mask)) && trig_data_trace) |=> trace_mode_field[TM_DATA_BIT])
    else $error("trigger start did not set trace mode");

  a_trace_event: assert property (@(posedge clk) disable iff (!rst_n)
    (look && !tm_r[TM_DATA_BIT]) |=> !data_trace_event)
    else $error("starting event leaked into data trace");

  a_tcodes: assert property (@(posedge clk) disable iff (!rst_n)
    watch_hit_message_valid |-> (watch_hit_message_tcode == 6'h0f) &&
      (watch_hit_message_hits != '0))
    else $error("watch hit message malformed");

  a_twh_code: assert property (@(posedge clk) disable iff (!rst_n)
    trace_watch_hit_message_valid |-> (trace_watch_hit_message_tcode == 6'h38) &&
      $past(trace_watch_hit) == trace_watch_hit_message_hits)
    else $error("trace watch hit message malformed");
endmodule
`default_nettype wire
